// [src/usn_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Bit 6: holding and shifter empty
// - Bit 5: holding empty, write clears
// - Bit 4: long low line flags break
// - Bit 3: bad stop bit flags framing
// - Bit 2: failed parity check flagged
// - Bit 1: unread byte overwritten flags overrun
// - Bit 0: data ready, cleared reading data
// - Live modem lines; carrier change latched
// - Ring rising edge latched, read clears
// - Set ready change latched, read clears
// - Clear to send change latched
// - Eight bit scratch register
// - Bit 15 selects fractional baud generator
// - Network mode only while bit 7 set
// - No parity check in network mode
// - Bit 0 is ninth transmitted bit
// - Bit 6 enables nine bit transmit
// - Bit 5 enables nine bit receive
// - Bit 3 selects nine bit word while bit 6 clear
// - Bit 2 enables output driver
// - Bit 4 gates irq, bit 1 polarity
// - Node address register, match raises status
// - Match needs receive full enable bit
//////////////////////////////////////////////////////////////////////////////
package usn_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_DATA = 32'hFFFF0700;
  localparam logic [31:0] ADDR_IER0 = 32'hFFFF0704;
  localparam logic [31:0] ADDR_LSR = 32'hFFFF0714;
  localparam logic [31:0] ADDR_MSR = 32'hFFFF0718;
  localparam logic [31:0] ADDR_SCR = 32'hFFFF071C;
  localparam logic [31:0] ADDR_NEN = 32'hFFFF0720;
  localparam logic [31:0] ADDR_NIID = 32'hFFFF0724;
  localparam logic [31:0] ADDR_NADR = 32'hFFFF0728;
  localparam logic [31:0] ADDR_FDIV = 32'hFFFF072C;
  // Reset values
  localparam logic [7:0] SCR_RST = 8'h00;
  localparam logic [7:0] NEN_RST = 8'h04;
  localparam logic [7:0] NADR_RST = 8'hAA;
  localparam logic [15:0] FDIV_RST = 16'h0000;
  localparam logic [7:0] NIID_IDLE = 8'h01;
  localparam logic [7:0] NIID_MATCH = 8'h0C;
  // Network enable field positions
  localparam int NEN_NETWORK_MODE_ENABLE = 7;
  localparam int NEN_NINEBIT_TX_ENABLE = 6;
  localparam int NEN_NINEBIT_RX_ENABLE = 5;
  localparam int NEN_ENI = 4;
  localparam int NEN_NINEBIT_WORD_LENGTH = 3;
  localparam int NEN_ETD = 2;
  localparam int NEN_ADDRESS_BIT_POLARITY = 1;
  localparam int NEN_NAB = 0;
  // Fractional divider field positions
  localparam int FD_EN = 15;
  localparam int FD_M_HI = 12;
  localparam int FD_M_LO = 11;
  localparam int FD_N_HI = 10;
  // Interrupt enable 0: receive full enable
  localparam int IER0_RXF = 0;
endpackage : usn_pkg

// [src/usn_top.sv]
module usn_top
  import usn_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Modem pins
  input wire logic dcd_pin,
  input wire logic ri_pin,
  input wire logic dsr_pin,
  input wire logic cts_pin,
  // Receive side of core shifter
  input wire logic rx_char_valid,
  input wire logic [8:0] rx_char_data,
  input wire logic rx_stop_bad,
  input wire logic rx_parity_bad,
  input wire logic rx_break_det,
  // Transmit side of core shifter
  output logic tx_hold_valid,
  output logic [7:0] tx_hold_data,
  input wire logic tx_take,
  input wire logic tx_shift_busy,
  input wire logic tx_line,
  // Shifter configuration
  output logic tx_ninth_bit,
  output logic tx_nine_bit_frame,
  output logic rx_nine_bit_frame,
  output logic nine_bit_word,
  output logic parity_check_en,
  // Baud generator configuration
  output logic frac_baud_enable,
  output logic [2:0] frac_m_field,
  output logic [10:0] frac_n_field,
  // Serial output pin
  output logic serial_out,
  output logic serial_out_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic dph_wr_ff; // Write data phase pending
  logic [31:0] dph_addr_ff; // Latched write address
  logic [31:0] hrdata_ff; // Registered read data
  logic [3:0] mdm_meta_ff; // First synchroniser stage
  logic [3:0] mdm_sync_ff; // Synced dcd,ri,dsr,cts
  logic [3:0] mdm_prev_ff; // Previous synced value
  logic [3:0] delta_ff; // Latched modem changes
  logic [7:0] scr_ff; // Scratch storage
  logic [7:0] nen_ff; // Network enable
  logic [7:0] nadr_ff; // Node address
  logic [15:0] fdiv_ff; // Fractional divider
  logic ier0_ff; // Receive full enable
  logic [8:0] rx_hold_ff; // Receive holding
  logic dr_ff; // Data ready
  logic oe_ff; // Overrun
  logic pe_ff; // Parity error
  logic fe_ff; // Framing error
  logic bi_ff; // Break
  logic match_ff; // Address match seen
  logic tx_full_ff; // Transmit holding full
  logic [7:0] tx_data_ff; // Transmit holding data
  logic serial_out_ff; // Registered line
  logic serial_out_oe_n_ff; // Registered enable

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Taken when selected, active and the bus is ready
  wire acc = hsel & htrans[1] & hready;
  wire rd_acc = acc & ~hwrite;
  wire wr_acc = acc & hwrite;
  wire rd_rx = rd_acc & (haddr == ADDR_DATA);
  wire rd_lsr = rd_acc & (haddr == ADDR_LSR);
  wire rd_msr = rd_acc & (haddr == ADDR_MSR);
  // Writes act in the data phase on the latched address
  wire wr_tx = dph_wr_ff & (dph_addr_ff == ADDR_DATA);
  wire wr_ier0 = dph_wr_ff & (dph_addr_ff == ADDR_IER0);
  wire wr_scr = dph_wr_ff & (dph_addr_ff == ADDR_SCR);
  wire wr_nen = dph_wr_ff & (dph_addr_ff == ADDR_NEN);
  wire wr_nadr = dph_wr_ff & (dph_addr_ff == ADDR_NADR);
  wire wr_fdiv = dph_wr_ff & (dph_addr_ff == ADDR_FDIV);

  ////////////////////////////////////////////////////////////////////////////
  // Status words
  wire network_mode_enable = nen_ff[NEN_NETWORK_MODE_ENABLE];
  // Line status, bit 7 reserved and reads zero
  wire [7:0] lsr_val = {1'b0,
                        ~tx_full_ff & ~tx_shift_busy,
                        ~tx_full_ff,
                        bi_ff, fe_ff, pe_ff, oe_ff, dr_ff};
  // Live modem levels above the latched changes
  wire [7:0] msr_val = {mdm_sync_ff, delta_ff};
  // Match reported only with both enables set
  wire match_irq = match_ff & nen_ff[NEN_ENI] & ier0_ff;
  wire [7:0] niid_val = match_irq ? NIID_MATCH : NIID_IDLE;

  // Read data select
  wire [31:0] rd_mux =
    (haddr == ADDR_DATA) ? {23'h000000, rx_hold_ff} :
    (haddr == ADDR_IER0) ? {31'h00000000, ier0_ff} :
    (haddr == ADDR_LSR) ? {24'h000000, lsr_val} :
    (haddr == ADDR_MSR) ? {24'h000000, msr_val} :
    (haddr == ADDR_SCR) ? {24'h000000, scr_ff} :
    (haddr == ADDR_NEN) ? {24'h000000, nen_ff} :
    (haddr == ADDR_NIID) ? {24'h000000, niid_val} :
    (haddr == ADDR_NADR) ? {24'h000000, nadr_ff} :
    (haddr == ADDR_FDIV) ? {16'h0000, fdiv_ff} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Receive character classification
  wire rx_is_addr = network_mode_enable & nen_ff[NEN_NINEBIT_RX_ENABLE]
                    & (rx_char_data[8] == nen_ff[NEN_ADDRESS_BIT_POLARITY]);
  wire rx_addr_hit = rx_char_valid & rx_is_addr
                     & (rx_char_data[7:0] == nadr_ff);
  // Unmatched addresses are dropped, matched ones reach the holding
  wire rx_load = rx_char_valid & (~rx_is_addr | rx_addr_hit);

  // Modem change sources
  wire [3:0] mdm_chg = mdm_sync_ff ^ mdm_prev_ff;
  // Ring latches on its rising edge only
  wire [3:0] delta_set = {mdm_chg[3],
                          mdm_sync_ff[2] & ~mdm_prev_ff[2],
                          mdm_chg[1],
                          mdm_chg[0]};
  // Set wins over the read clear
  wire [3:0] nxt_delta = (delta_ff & ~{4{rd_msr}}) | delta_set;

  // Line status next values
  wire nxt_dr = (dr_ff & ~rd_rx) | rx_load;
  // Error flags clear on a line status read
  wire nxt_oe = (oe_ff & ~rd_lsr) | (rx_load & dr_ff);
  wire nxt_pe = (pe_ff & ~rd_lsr)
                | (rx_load & rx_parity_bad & ~network_mode_enable);
  wire nxt_fe = (fe_ff & ~rd_lsr) | (rx_load & rx_stop_bad);
  wire nxt_bi = (bi_ff & ~rd_lsr) | rx_break_det;
  // Match clears with the receive data read
  wire nxt_match = (match_ff & ~rd_rx) | rx_addr_hit;
  // Write wins over the shifter taking the old byte
  wire nxt_tx_full = wr_tx | (tx_full_ff & ~tx_take);

  ////////////////////////////////////////////////////////////////////////////
  // Modem pin synchronisers, one per line
  // Stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          mdm_meta_ff[gi] <= 1'b0;
          mdm_sync_ff[gi] <= 1'b0;
          mdm_prev_ff[gi] <= 1'b0;
        end else begin
          mdm_meta_ff[gi] <= (gi == 3) ? dcd_pin : (gi == 2) ? ri_pin :
                             (gi == 1) ? dsr_pin : cts_pin;
          mdm_sync_ff[gi] <= mdm_meta_ff[gi];
          mdm_prev_ff[gi] <= mdm_sync_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking and read data
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dph_wr_ff <= 1'b0;
      dph_addr_ff <= 32'h00000000;
      hrdata_ff <= 32'h00000000;
    end else begin
      dph_wr_ff <= wr_acc;
      // Keep last address when idle
      if (acc) begin
        dph_addr_ff <= haddr;
      end
      // Capture read data at address phase
      if (rd_acc) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  // Loaded in the data phase from the bus data
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scr_ff <= SCR_RST;
      nen_ff <= NEN_RST;
      nadr_ff <= NADR_RST;
      fdiv_ff <= FDIV_RST;
      ier0_ff <= 1'b0;
    end else begin
      // Scratch storage
      if (wr_scr) begin
        scr_ff <= hwdata[7:0];
      end
      // Network enable
      if (wr_nen) begin
        nen_ff <= hwdata[7:0];
      end
      // Node address
      if (wr_nadr) begin
        nadr_ff <= hwdata[7:0];
      end
      // Fractional divider
      if (wr_fdiv) begin
        fdiv_ff <= hwdata[15:0];
      end
      // Receive full enable
      if (wr_ier0) begin
        ier0_ff <= hwdata[IER0_RXF];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding and line status flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_hold_ff <= 9'h000;
      dr_ff <= 1'b0;
      oe_ff <= 1'b0;
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
      bi_ff <= 1'b0;
      match_ff <= 1'b0;
      delta_ff <= 4'h0;
    end else begin
      // New character overwrites holding
      if (rx_load) begin
        rx_hold_ff <= rx_char_data;
      end
      dr_ff <= nxt_dr;
      oe_ff <= nxt_oe;
      pe_ff <= nxt_pe;
      fe_ff <= nxt_fe;
      bi_ff <= nxt_bi;
      match_ff <= nxt_match;
      delta_ff <= nxt_delta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding and pin drive
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_full_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      serial_out_ff <= 1'b1;
      serial_out_oe_n_ff <= 1'b0;
    end else begin
      tx_full_ff <= nxt_tx_full;
      // Software byte into holding
      if (wr_tx) begin
        tx_data_ff <= hwdata[7:0];
      end
      // Line level reaches the pin one clock later
      serial_out_ff <= tx_line;
      // Released only when network mode asks for it
      serial_out_oe_n_ff <= network_mode_enable & ~nen_ff[NEN_ETD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // No wait states, always an OKAY response
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign tx_hold_valid = tx_full_ff;
  assign tx_hold_data = tx_data_ff;
  // Nine bit framing only while network mode is on
  assign tx_nine_bit_frame = network_mode_enable & nen_ff[NEN_NINEBIT_TX_ENABLE];
  assign tx_ninth_bit = tx_nine_bit_frame & nen_ff[NEN_NAB];
  assign rx_nine_bit_frame = network_mode_enable & nen_ff[NEN_NINEBIT_RX_ENABLE];
  // Nine bit data words need nine bit transmit off
  assign nine_bit_word = nen_ff[NEN_NINEBIT_WORD_LENGTH] & ~nen_ff[NEN_NINEBIT_TX_ENABLE];
  // Parity checking off in network mode
  assign parity_check_en = ~network_mode_enable;
  assign frac_baud_enable = fdiv_ff[FD_EN];
  // Zero in the M field stands for four
  assign frac_m_field = (fdiv_ff[FD_M_HI:FD_M_LO] == 2'h0) ? 3'h4 :
                        {1'b0, fdiv_ff[FD_M_HI:FD_M_LO]};
  assign frac_n_field = fdiv_ff[FD_N_HI:0];
  assign serial_out = serial_out_ff;
  assign serial_out_oe_n = serial_out_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // All on the system clock, off during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_tx_holding_empty_clear: assert property (wr_tx |=> !lsr_val[5])
    else $error("holding empty not cleared by write");
  chk_tx_all_empty_clear: assert property (wr_tx |=> !lsr_val[6])
    else $error("all empty not cleared by write");
  chk_dr_set: assert property (rx_load |=> dr_ff)
    else $error("data ready not set");
  chk_dr_clear: assert property (rd_rx && !rx_load |=> !dr_ff)
    else $error("data ready not cleared by read");
  chk_overrun_set: assert property (rx_load && dr_ff |=> oe_ff)
    else $error("overrun missed");
  chk_no_parity_net: assert property (network_mode_enable && !pe_ff |=> !pe_ff)
    else $error("parity flagged in network mode");
  chk_ring_edge: assert property ($rose(mdm_sync_ff[2]) |=> delta_ff[2])
    else $error("ring edge not latched");
  chk_delta_clear: assert property (rd_msr && delta_set == 4'h0 |=> delta_ff == 4'h0)
    else $error("modem deltas not cleared by read");
  chk_pin_release: assert property (
      network_mode_enable && !nen_ff[NEN_ETD] |=> serial_out_oe_n)
    else $error("output pin not released");
  chk_match_id: assert property (
      rx_addr_hit && nen_ff[NEN_ENI] && ier0_ff && !wr_nen && !wr_ier0
      |=> niid_val == NIID_MATCH)
    else $error("address match not reported");

  // Receive errors follow the shifter qualifiers
  chk_break_set: assert property (rx_break_det |=> bi_ff)
    else $error("break not flagged");
  chk_frame_set: assert property (rx_load && rx_stop_bad |=> fe_ff)
    else $error("framing error not flagged");
  chk_parity_set: assert property (rx_load && rx_parity_bad && !network_mode_enable |=> pe_ff)
    else $error("parity error not flagged");
  chk_flags_clear: assert property (
      rd_lsr && !rx_load && !rx_break_det |=> !oe_ff && !pe_ff && !fe_ff && !bi_ff)
    else $error("line errors not cleared by status read");
  chk_data_held: assert property (rx_load |=> rx_hold_ff == $past(rx_char_data))
    else $error("received character not held");

  // Transmit holding
  chk_tx_data: assert property (wr_tx |=> tx_hold_data == $past(hwdata[7:0]))
    else $error("transmit byte not held");
  chk_tx_holding_empty_set: assert property (tx_take && !wr_tx |=> lsr_val[5])
    else $error("holding empty not set after take");

  // Modem change latches
  chk_dcd_change: assert property (mdm_chg[3] |=> delta_ff[3])
    else $error("carrier change not latched");
  chk_ring_fall: assert property (
      $fell(mdm_sync_ff[2]) && !delta_ff[2] |=> !delta_ff[2])
    else $error("ring falling edge latched");
  chk_dsr_change: assert property (mdm_chg[1] |=> delta_ff[1])
    else $error("set ready change not latched");
  chk_cts_change: assert property (mdm_chg[0] |=> delta_ff[0])
    else $error("clear to send change not latched");

  // Software registers and network mode
  chk_scr_write: assert property (wr_scr |=> scr_ff == $past(hwdata[7:0]))
    else $error("scratch write lost");
  chk_fdiv_write: assert property (
      wr_fdiv |=> frac_baud_enable == $past(hwdata[FD_EN]))
    else $error("fractional enable not taken");
  chk_net_off: assert property (
      !network_mode_enable |-> !tx_nine_bit_frame && !rx_nine_bit_frame && parity_check_en)
    else $error("network behaviour outside network mode");
  chk_addr_drop: assert property (
      rx_char_valid && rx_is_addr && !rx_addr_hit |=> $stable(rx_hold_ff))
    else $error("unmatched address reached the holding");
  chk_match_clear: assert property (rd_rx && !rx_addr_hit |=> !match_ff)
    else $error("match not cleared by data read");
  chk_niid_idle: assert property (rd_rx && !rx_addr_hit |=> niid_val == NIID_IDLE)
    else $error("network id not idle after data read");
  chk_pin_driven: assert property (!network_mode_enable || nen_ff[NEN_ETD] |=> !serial_out_oe_n)
    else $error("output pin released while enabled");

endmodule : usn_top

// [verification/uart_status_and_network_mode_tb_top.sv]
module uart_status_and_network_mode_tb_top
  import usn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus master side
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // Far side and design outputs
  logic dcd_pin, ri_pin, dsr_pin, cts_pin, rx_char_valid, rx_stop_bad, rx_parity_bad;
  logic rx_break_det, tx_take, tx_shift_busy, tx_line, tx_hold_valid, tx_ninth_bit;
  logic tx_nine_bit_frame, rx_nine_bit_frame, nine_bit_word, parity_check_en;
  logic frac_baud_enable, serial_out, serial_out_oe_n;
  logic [8:0] rx_char_data;
  logic [7:0] tx_hold_data;
  logic [2:0] frac_m_field;
  logic [10:0] frac_n_field;
  int miscompares, samples_checked;
  // Reset table: address and value
  localparam logic [31:0] RA [8] = '{ADDR_LSR, ADDR_MSR, ADDR_SCR, ADDR_NEN,
    ADDR_NIID, ADDR_NADR, ADDR_FDIV, 32'hFFFF0730};
  localparam logic [31:0] RV [8] = '{32'h60, 32'h0, 32'h0, 32'h4, 32'h1, 32'hAA, 32'h0, 32'h0};

  usn_top usn_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dcd_pin(dcd_pin),
    .ri_pin(ri_pin), .dsr_pin(dsr_pin), .cts_pin(cts_pin), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_stop_bad(rx_stop_bad), .rx_parity_bad(rx_parity_bad),
    .rx_break_det(rx_break_det), .tx_hold_valid(tx_hold_valid), .tx_hold_data(tx_hold_data),
    .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .tx_line(tx_line),
    .tx_ninth_bit(tx_ninth_bit), .tx_nine_bit_frame(tx_nine_bit_frame),
    .rx_nine_bit_frame(rx_nine_bit_frame), .nine_bit_word(nine_bit_word),
    .parity_check_en(parity_check_en), .frac_baud_enable(frac_baud_enable),
    .frac_m_field(frac_m_field), .frac_n_field(frac_n_field), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
  );
  usn_far_model usn_far_model_inst (
    .sys_clk(sys_clk), .nrst(nrst), .tx_hold_valid(tx_hold_valid), .tx_take(tx_take),
    .tx_shift_busy(tx_shift_busy), .tx_line(tx_line), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_stop_bad(rx_stop_bad), .rx_parity_bad(rx_parity_bad),
    .rx_break_det(rx_break_det), .dcd_pin(dcd_pin), .ri_pin(ri_pin), .dsr_pin(dsr_pin),
    .cts_pin(cts_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : bus

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Let registered outputs land
  task settle;
    repeat (2) @(negedge sys_clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int i = 0; i < 8; i++) rdc(RA[i], RV[i]);
    chk(32'({parity_check_en, frac_m_field, serial_out_oe_n}), 32'h18);
    chk(32'({hreadyout, hresp}), 32'h2);
    $display("test reset done");
  endtask : t_reset

  task t_regs;
    bus(1'b1, ADDR_SCR, 32'hA5);
    rdc(ADDR_SCR, 32'hA5);
    bus(1'b1, ADDR_FDIV, 32'h9123);
    rdc(ADDR_FDIV, 32'h9123);
    chk(32'({frac_baud_enable, frac_m_field, frac_n_field}), 32'h5123);
    bus(1'b1, ADDR_FDIV, 32'h0);
    settle;
    chk(32'({frac_baud_enable, frac_m_field}), 32'h4);
    $display("test regs done");
  endtask : t_regs

  task t_tx;
    bus(1'b1, ADDR_DATA, 32'h55);
    rdc(ADDR_LSR, 32'h0);
    chk(32'({tx_hold_valid, tx_hold_data}), 32'h155);
    for (int i = 0; i < 50 && tx_hold_valid !== 1'b0; i++) @(posedge sys_clk);
    rdc(ADDR_LSR, 32'h20);
    @(negedge sys_clk);
    chk(32'(serial_out), 32'h0);
    for (int i = 0; i < 50 && tx_shift_busy !== 1'b0; i++) @(posedge sys_clk);
    rdc(ADDR_LSR, 32'h60);
    $display("test tx done");
  endtask : t_tx

  task t_rx;
    usn_far_model_inst.send(9'h03A, 1'b1, 1'b1, 1'b0);
    rdc(ADDR_LSR, 32'h6D);
    usn_far_model_inst.send(9'h0C3, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_LSR, 32'h63);
    usn_far_model_inst.send(9'h0, 1'b0, 1'b0, 1'b1);
    rdc(ADDR_LSR, 32'h71);
    rdc(ADDR_DATA, 32'hC3);
    rdc(ADDR_LSR, 32'h60);
    $display("test rx done");
  endtask : t_rx

  task t_modem;
    usn_far_model_inst.modem(4'hF);
    repeat (5) @(posedge sys_clk);
    rdc(ADDR_MSR, 32'hFF);
    rdc(ADDR_MSR, 32'hF0);
    usn_far_model_inst.modem(4'hA);
    repeat (5) @(posedge sys_clk);
    rdc(ADDR_MSR, 32'hA1);
    $display("test modem done");
  endtask : t_modem

  task t_net;
    bus(1'b1, ADDR_NEN, 32'h80);
    settle;
    chk(32'({serial_out_oe_n, parity_check_en}), 32'h2);
    usn_far_model_inst.send(9'h011, 1'b0, 1'b1, 1'b0);
    rdc(ADDR_LSR, 32'h61);
    rdc(ADDR_DATA, 32'h11);
    bus(1'b1, ADDR_NEN, 32'h44);
    settle;
    chk(32'({tx_nine_bit_frame, tx_ninth_bit, rx_nine_bit_frame}), 32'h0);
    chk(32'(serial_out_oe_n), 32'h0);
    bus(1'b1, ADDR_NEN, 32'hE7);
    settle;
    chk(32'({tx_nine_bit_frame, tx_ninth_bit, rx_nine_bit_frame, nine_bit_word}), 32'hE);
    bus(1'b1, ADDR_NEN, 32'hBE);
    settle;
    chk(32'({tx_nine_bit_frame, tx_ninth_bit, rx_nine_bit_frame, nine_bit_word}), 32'h3);
    bus(1'b1, ADDR_NADR, 32'h5C);
    usn_far_model_inst.send(9'h15C, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_NIID, 32'h1);
    rdc(ADDR_DATA, 32'h15C);
    bus(1'b1, ADDR_IER0, 32'h1);
    usn_far_model_inst.send(9'h15C, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_NIID, 32'hC);
    rdc(ADDR_DATA, 32'h15C);
    rdc(ADDR_NIID, 32'h1);
    usn_far_model_inst.send(9'h133, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_LSR, 32'h60);
    bus(1'b1, ADDR_NEN, 32'hB0);
    usn_far_model_inst.send(9'h05C, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_NIID, 32'hC);
    rdc(ADDR_DATA, 32'h5C);
    usn_far_model_inst.send(9'h15C, 1'b0, 1'b0, 1'b0);
    rdc(ADDR_NIID, 32'h1);
    rdc(ADDR_DATA, 32'h15C);
    $display("test net done");
  endtask : t_net

  ////////////////////////////////////////////////////////////////////////////
  // Counts, verdict and stop
  task end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Watchdog: tests need a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end

  // Main sequence
  initial begin
    {nrst, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_modem;
    t_net;
    end_sim;
  end
endmodule : uart_status_and_network_mode_tb_top

// [verification/usn_far_model.sv]
module usn_far_model
  import usn_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Transmit shifter side
  input wire logic tx_hold_valid,
  output logic tx_take,
  output logic tx_shift_busy,
  output logic tx_line,
  // Receive shifter side
  output logic rx_char_valid,
  output logic [8:0] rx_char_data,
  output logic rx_stop_bad,
  output logic rx_parity_bad,
  output logic rx_break_det,
  // Modem pins
  output logic dcd_pin,
  output logic ri_pin,
  output logic dsr_pin,
  output logic cts_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stall and shift counter
  logic [3:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    {rx_char_valid, rx_char_data, rx_stop_bad, rx_parity_bad, rx_break_det} = '0;
    {dcd_pin, ri_pin, dsr_pin, cts_pin} = 4'h0;
  end

  // Slow shifter: stalls 8 cycles, then shifts 8 cycles with line low
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
      tx_take <= 1'b0;
      tx_shift_busy <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      tx_take <= 1'b0;
      tx_line <= !tx_shift_busy;
      if (tx_shift_busy || tx_hold_valid) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (cnt_ff == 4'h7) begin
        cnt_ff <= 4'h0;
        tx_take <= !tx_shift_busy;
        tx_shift_busy <= !tx_shift_busy;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One character or a break pulse; data, stop and parity lines then show the inverse
  task send(input logic [8:0] d, input logic sb, input logic pb, input logic bk);
    @(posedge sys_clk);
    rx_char_valid <= !bk;
    rx_break_det <= bk;
    rx_char_data <= d;
    rx_stop_bad <= sb;
    rx_parity_bad <= pb;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_break_det <= 1'b0;
    rx_char_data <= ~d;
    rx_stop_bad <= ~sb;
    rx_parity_bad <= ~pb;
  endtask : send

  // Modem levels: carrier, ring, set ready, clear to send
  task modem(input logic [3:0] p);
    @(posedge sys_clk);
    {dcd_pin, ri_pin, dsr_pin, cts_pin} <= p;
  endtask : modem
endmodule : usn_far_model
